// File: hw/sldd_top.sv
// Register file and decode top for the low DRAM limit and SMM window.

// Notes on behaviour
// RULE_01: Limit byte bits 7:3 hold address bits 31:27; field resets to 01h.
// RULE_02: Low limit bits are zero; addresses strictly below the limit go to DRAM.
// RULE_03: Software programs the limit to min of memory+1 and lowest PCI address.
// RULE_04: A zero limit field means 128 MB, same as value one.
// RULE_05: An enabled extended segment takes 1, 2 or 8 MB below the limit.
// RULE_06: The extended segment ends immediately below the limit address.
// RULE_07: Open, closed and lock act only while global SMM RAM enable is set.
// RULE_08: Software clears the open bit before setting the lock bit.
// RULE_09: Open set and lock clear makes SMM DRAM visible to non-SMM requests.
// RULE_10: Software never sets open and closed together.
// RULE_11: Closed refuses data references to the SMM window; code fetches still pass.
// RULE_12: Closed affects only the compatible window, not the extended segment.
// RULE_13: Writing lock clears open and freezes lock, open, segment and enable controls.
// RULE_14: Lock is set by a write and cleared only by full reset.
// RULE_15: Global enable exposes the 128 KB window to SMM requests; frozen by lock.
// RULE_16: Base segment reads 010; refused window accesses go to the hub link.
// RULE_17: Size code 00 is 1 MB, 01 is 2 MB, 10 is 8 MB; 11 reserved.
// RULE_18: Limit bits 2:0 and control bit 7 read zero and ignore writes.
module sldd_top
(
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Configuration byte access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Extended segment controls from the neighbouring control register
  input wire logic ext_seg_en_i,
  input wire logic [1:0] ext_seg_size_i,
  input wire logic high_smm_en_i,
  // Host request
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire logic req_smm_i,
  input wire logic req_code_i,
  // Routing answer
  output logic rsp_valid_o,
  output logic rsp_to_dram_o,
  output logic rsp_to_hub_o,
  // Live control state
  output logic smm_lock_o,
  output logic [sldd_pkg::SLDD_LIM_W-1:0] limit_field_o
);
  import sldd_pkg::*;

  sldd_cfg_if cfg_if ();

  logic [SLDD_LIM_W-1:0] limit_q;
  logic open_q;
  logic closed_q;
  logic lock_q;
  logic gen_q;
  logic ext_en_q;
  logic [1:0] ext_size_q;
  logic high_en_q;
  logic wr_limit;
  logic wr_smm;
  logic [7:0] rdata_d;
  logic [7:0] rd_addr_q;

  assign wr_limit = ce_i && cfg_wr_i && (cfg_addr_i == SLDD_OFS_LIMIT);
  assign wr_smm = ce_i && cfg_wr_i && (cfg_addr_i == SLDD_OFS_SMMCTL);

  // Low DRAM limit byte.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      limit_q <= SLDD_RST_LIMIT[SLDD_LIM_MSB:SLDD_LIM_LSB]; // RULE_01
    end
    else if (wr_limit)
    begin
      limit_q <= cfg_wdata_i[SLDD_LIM_MSB:SLDD_LIM_LSB]; // RULE_01 RULE_18
    end
  end

  // Lock: set by a write, cleared only by reset. A lock write while the global
  // enable is clear, and stays clear, leaves lock clear but still forces open low.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lock_q <= SLDD_RST_SMMCTL[SLDD_BIT_LOCK]; // RULE_14
    end
    else if (wr_smm && !lock_q && cfg_wdata_i[SLDD_BIT_LOCK] &&
             (gen_q || cfg_wdata_i[SLDD_BIT_GEN]))
    begin
      lock_q <= 1'b1; // RULE_07 RULE_14
    end
  end

  // Open, global enable: writable until locked; lock forces open low.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      open_q <= SLDD_RST_SMMCTL[SLDD_BIT_OPEN];
      gen_q <= SLDD_RST_SMMCTL[SLDD_BIT_GEN];
    end
    else if (wr_smm && !lock_q)
    begin
      open_q <= cfg_wdata_i[SLDD_BIT_OPEN] && !cfg_wdata_i[SLDD_BIT_LOCK]; // RULE_13
      gen_q <= cfg_wdata_i[SLDD_BIT_GEN]; // RULE_15
    end
  end

  // Closed stays writable after lock so SMM code can still toggle it.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      closed_q <= SLDD_RST_SMMCTL[SLDD_BIT_CLOSED];
    end
    else if (wr_smm)
    begin
      closed_q <= cfg_wdata_i[SLDD_BIT_CLOSED]; // RULE_11
    end
  end

  // Extended segment controls follow their inputs until lock, then freeze.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ext_en_q <= 1'b0;
      ext_size_q <= SLDD_SZ_1M;
      high_en_q <= 1'b0;
    end
    else if (ce_i && !lock_q)
    begin
      ext_en_q <= ext_seg_en_i; // RULE_13
      ext_size_q <= ext_seg_size_i; // RULE_13
      high_en_q <= high_smm_en_i; // RULE_13
    end
  end

  // Read mux; reserved bits are zero and unmapped offsets read zero.
  always_comb
  begin
    rdata_d = '0;
    if (cfg_addr_i == SLDD_OFS_LIMIT)
    begin
      rdata_d[SLDD_LIM_MSB:SLDD_LIM_LSB] = limit_q; // RULE_18
    end
    else if (cfg_addr_i == SLDD_OFS_SMMCTL)
    begin
      rdata_d[SLDD_BIT_OPEN] = open_q;
      rdata_d[SLDD_BIT_CLOSED] = closed_q;
      rdata_d[SLDD_BIT_LOCK] = lock_q;
      rdata_d[SLDD_BIT_GEN] = gen_q;
      rdata_d[2:0] = SLDD_BASE_SEG; // RULE_16
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cfg_rdata_o <= '0;
      cfg_rvalid_o <= 1'b0;
      rd_addr_q <= '0;
    end
    else if (ce_i)
    begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i)
      begin
        cfg_rdata_o <= rdata_d;
        rd_addr_q <= cfg_addr_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      smm_lock_o <= 1'b0;
      limit_field_o <= SLDD_RST_LIMIT[SLDD_LIM_MSB:SLDD_LIM_LSB];
    end
    else if (ce_i)
    begin
      smm_lock_o <= lock_q;
      limit_field_o <= limit_q;
    end
  end

  // Open, closed and lock are gated by the global enable in the decoder.
  assign cfg_if.limit_field = limit_q;
  assign cfg_if.global_en = gen_q;
  assign cfg_if.open_bit = open_q;
  assign cfg_if.closed_bit = closed_q;
  assign cfg_if.lock_bit = lock_q;
  assign cfg_if.ext_en = ext_en_q;
  assign cfg_if.ext_size = ext_size_q;
  assign cfg_if.high_en = high_en_q;

  sldd_decode u_decode (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .cfg(cfg_if.dec),
    .req_valid_i(req_valid_i),
    .req_addr_i(req_addr_i),
    .req_smm_i(req_smm_i),
    .req_code_i(req_code_i),
    .rsp_valid_o(rsp_valid_o),
    .rsp_to_dram_o(rsp_to_dram_o),
    .rsp_to_hub_o(rsp_to_hub_o)
  );

  // Helper terms for the checks below.
  logic [31:0] lim_addr_chk;
  logic compat_chk;
  assign lim_addr_chk = {((limit_q == '0) ? SLDD_LIM_MIN : limit_q), 27'h0000000};
  assign compat_chk = (req_addr_i >= SLDD_COMPAT_LO) && (req_addr_i <= SLDD_COMPAT_HI);
  // The top megabyte below the limit lies inside every legal segment size.
  logic top_mb_chk;
  assign top_mb_chk = (req_addr_i >= lim_addr_chk - SLDD_BYTES_1M) &&
                      (req_addr_i < lim_addr_chk);

  a_lock_sticky: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_14
    lock_q |=> lock_q)
    else $error("Lock bit cleared without reset.");

  a_lock_open_low: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_13
    wr_smm && cfg_wdata_i[SLDD_BIT_LOCK] && gen_q |=> lock_q && !open_q)
    else $error("Lock write left open set.");

  a_locked_frozen: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_13
    lock_q |=> $stable(gen_q) && $stable(ext_size_q) && $stable(ext_en_q) && !open_q)
    else $error("Locked control changed.");

  a_limit_write: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_01
    wr_limit |=> limit_q == $past(cfg_wdata_i[SLDD_LIM_MSB:SLDD_LIM_LSB]))
    else $error("Limit write not stored.");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_18
    cfg_rvalid_o && (rd_addr_q == SLDD_OFS_LIMIT) |-> cfg_rdata_o[2:0] == 3'h0)
    else $error("Limit reserved bits not zero.");

  a_base_seg_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_16
    cfg_rvalid_o && (rd_addr_q == SLDD_OFS_SMMCTL) |->
      cfg_rdata_o[2:0] == SLDD_BASE_SEG && !cfg_rdata_o[7])
    else $error("Control byte fixed bits wrong.");

  a_above_limit: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_02
    ce_i && req_valid_i && (req_addr_i >= lim_addr_chk) |=> rsp_valid_o && rsp_to_hub_o)
    else $error("Address above limit sent to DRAM.");

  a_closed_data: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_11
    ce_i && req_valid_i && compat_chk && gen_q && closed_q && !req_code_i &&
      !(open_q && !lock_q) |=> rsp_to_hub_o)
    else $error("Data reference passed a closed window.");

  a_open_visible: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_09
    ce_i && req_valid_i && compat_chk && gen_q && open_q && !lock_q |=> rsp_to_dram_o)
    else $error("Open window not visible.");

  a_no_global: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_07
    ce_i && req_valid_i && compat_chk && !gen_q |=> rsp_to_hub_o)
    else $error("Window reached without global enable.");

  a_closed_writable: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_11
    wr_smm |=> closed_q == $past(cfg_wdata_i[SLDD_BIT_CLOSED]))
    else $error("Closed bit write not stored.");

  a_high_frozen: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_13
    lock_q |=> $stable(high_en_q))
    else $error("High enable changed after lock.");

  a_ce_freeze: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !ce_i |=> $stable(limit_q) && $stable(lock_q) && $stable(open_q) && $stable(gen_q) &&
      $stable(closed_q) && $stable(cfg_rvalid_o) && $stable(rsp_valid_o))
    else $error("State moved while the clock enable was low.");

  a_rd_answer: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ce_i && cfg_rd_i |=> cfg_rvalid_o)
    else $error("Read strobe got no answer.");

  a_rsp_onehot: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_16
    (rsp_valid_o == (rsp_to_dram_o || rsp_to_hub_o)) && !(rsp_to_dram_o && rsp_to_hub_o))
    else $error("Routing answer not one-hot.");

  a_ext_nonsmm_hub: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_05
    ce_i && req_valid_i && top_mb_chk && gen_q && ext_en_q && (ext_size_q != SLDD_SZ_RSVD) &&
      !req_smm_i && !(open_q && !lock_q) |=> rsp_to_hub_o)
    else $error("Non-SMM request reached the extended segment.");

  a_ext_smm_dram: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_06 RULE_12
    ce_i && req_valid_i && top_mb_chk && gen_q && ext_en_q && (ext_size_q != SLDD_SZ_RSVD) &&
      req_smm_i |=> rsp_to_dram_o)
    else $error("SMM request refused by the extended segment.");

  a_ext_off_dram: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_15
    ce_i && req_valid_i && top_mb_chk && !gen_q |=> rsp_to_dram_o)
    else $error("Segment claimed without global enable.");

  a_zero_limit: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_04
    ce_i && req_valid_i && (limit_q == '0) && (req_addr_i[31:SLDD_LIM_ADDR_LSB] == '0) &&
      !compat_chk && !(gen_q && ext_en_q) |=> rsp_to_dram_o)
    else $error("Zero limit did not keep the minimum memory.");

endmodule // sldd_top

// File: hw/sldd_pkg.sv
// Constants for the low DRAM limit and SMM window decode block.
package sldd_pkg;

  // Configuration byte offsets.
  localparam logic [7:0] SLDD_OFS_LIMIT = 8'h9c;
  localparam logic [7:0] SLDD_OFS_SMMCTL = 8'h9d;

  // Reset values of the two bytes.
  localparam logic [7:0] SLDD_RST_LIMIT = 8'h08;
  localparam logic [7:0] SLDD_RST_SMMCTL = 8'h02;

  // Field positions of the low DRAM limit byte.
  localparam int SLDD_LIM_MSB = 7;
  localparam int SLDD_LIM_LSB = 3;
  localparam int SLDD_LIM_W = SLDD_LIM_MSB - SLDD_LIM_LSB + 1;
  localparam int SLDD_LIM_ADDR_LSB = 27;

  // Field positions of the SMM control byte.
  localparam int SLDD_BIT_OPEN = 6;
  localparam int SLDD_BIT_CLOSED = 5;
  localparam int SLDD_BIT_LOCK = 4;
  localparam int SLDD_BIT_GEN = 3;
  localparam logic [2:0] SLDD_BASE_SEG = 3'h2;
  localparam logic [SLDD_LIM_W-1:0] SLDD_LIM_MIN = 5'h01;

  // Compatible SMM window.
  localparam logic [31:0] SLDD_COMPAT_LO = 32'h000a0000;
  localparam logic [31:0] SLDD_COMPAT_HI = 32'h000bffff;

  // Extended segment size codes and sizes.
  localparam logic [1:0] SLDD_SZ_1M = 2'h0;
  localparam logic [1:0] SLDD_SZ_2M = 2'h1;
  localparam logic [1:0] SLDD_SZ_8M = 2'h2;
  localparam logic [1:0] SLDD_SZ_RSVD = 2'h3;
  localparam logic [31:0] SLDD_BYTES_1M = 32'h00100000;
  localparam logic [31:0] SLDD_BYTES_2M = 32'h00200000;
  localparam logic [31:0] SLDD_BYTES_8M = 32'h00800000;

endpackage : sldd_pkg

// File: hw/sldd_cfg_if.sv
// Decode configuration carried from the register file to the decoder.
interface sldd_cfg_if;
  logic [sldd_pkg::SLDD_LIM_W-1:0] limit_field;
  logic global_en;
  logic open_bit;
  logic closed_bit;
  logic lock_bit;
  logic ext_en;
  logic [1:0] ext_size;
  logic high_en;

  modport regs (
    output limit_field, global_en, open_bit, closed_bit, lock_bit, ext_en, ext_size, high_en
  );
  modport dec (
    input limit_field, global_en, open_bit, closed_bit, lock_bit, ext_en, ext_size, high_en
  );
endinterface : sldd_cfg_if

// File: hw/sldd_decode.sv
// Host address decoder steering each request to DRAM or to the hub link.
module sldd_decode
  import sldd_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Configuration
  sldd_cfg_if.dec cfg,
  // Request
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire logic req_smm_i,
  input wire logic req_code_i,
  // Routing answer
  output logic rsp_valid_o,
  output logic rsp_to_dram_o,
  output logic rsp_to_hub_o
);
  import sldd_pkg::*;

  // Inclusive range check, used for both protected regions.
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [SLDD_LIM_W-1:0] lim_eff;
  logic [31:0] limit_addr;
  logic [31:0] seg_bytes;
  logic ext_active;
  logic in_compat;
  logic in_ext;
  logic open_eff;
  logic compat_ok;
  logic ext_ok;
  logic to_dram_d;

  always_comb
  begin
    // A zero field means the same 128 MB minimum as the value one.
    lim_eff = (cfg.limit_field == '0) ? SLDD_LIM_MIN : cfg.limit_field; // RULE_04
    limit_addr = {lim_eff, 27'h0000000}; // RULE_01 RULE_02
    case (cfg.ext_size) // RULE_17
      SLDD_SZ_1M: seg_bytes = SLDD_BYTES_1M;
      SLDD_SZ_2M: seg_bytes = SLDD_BYTES_2M;
      SLDD_SZ_8M: seg_bytes = SLDD_BYTES_8M;
      default: seg_bytes = '0;
    endcase
    // The reserved size code leaves the segment off rather than guessing a size.
    ext_active = cfg.global_en && cfg.ext_en && (cfg.ext_size != SLDD_SZ_RSVD); // RULE_15
    // The segment ends one byte below the limit.
    in_ext = ext_active && in_range(req_addr_i, limit_addr - seg_bytes,
                                    limit_addr - 32'h00000001); // RULE_05 RULE_06
    in_compat = in_range(req_addr_i, SLDD_COMPAT_LO, SLDD_COMPAT_HI); // RULE_16
    open_eff = cfg.global_en && cfg.open_bit && !cfg.lock_bit; // RULE_07 RULE_09
    compat_ok = cfg.global_en &&
                (open_eff || (req_smm_i && !(cfg.closed_bit && !req_code_i))); // RULE_11 RULE_15
    ext_ok = open_eff || req_smm_i; // RULE_12
    if (in_compat)
    begin
      to_dram_d = compat_ok; // RULE_16
    end
    else if (in_ext)
    begin
      to_dram_d = ext_ok;
    end
    else
    begin
      to_dram_d = req_addr_i < limit_addr; // RULE_02
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_to_dram_o <= 1'b0;
      rsp_to_hub_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rsp_valid_o <= req_valid_i;
      rsp_to_dram_o <= req_valid_i && to_dram_d;
      rsp_to_hub_o <= req_valid_i && !to_dram_d;
    end
  end

endmodule // sldd_decode

// File: tb/sldd_host_model.sv
// Processor-side model that issues one memory request at a time to the decode block.
module sldd_host_model
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Command from the bench
  input wire logic issue_i,
  input wire logic [31:0] addr_i,
  input wire logic smm_i,
  input wire logic code_i,
  // Request to the block
  output logic req_valid_o,
  output logic [31:0] req_addr_o,
  output logic req_smm_o,
  output logic req_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle cycles scramble the qualifiers so a stale request never passes for a live one.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      req_valid_o <= 1'h0;
      req_addr_o <= 32'h0;
      req_smm_o <= 1'h0;
      req_code_o <= 1'h0;
    end
    else
    begin
      req_valid_o <= issue_i;
      req_addr_o <= issue_i ? addr_i : ~req_addr_o;
      req_smm_o <= issue_i ? smm_i : ~req_smm_o;
      req_code_o <= issue_i ? code_i : ~req_code_o;
    end
  end
endmodule // sldd_host_model

// File: tb/sldd_top_tb.sv
// Self-checking bench for the low DRAM limit and SMM window decode block.
module sldd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sldd_pkg::*;
  logic core_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic cfg_wr_i = 1'h0;
  logic cfg_rd_i = 1'h0;
  logic [7:0] cfg_addr_i = 8'h0;
  logic [7:0] cfg_wdata_i = 8'h0;
  logic ext_seg_en_i = 1'h0;
  logic [1:0] ext_seg_size_i = 2'h0;
  logic high_smm_en_i = 1'h0;
  logic issue = 1'h0;
  logic [31:0] cmd_addr = 32'h0;
  logic cmd_smm = 1'h0;
  logic cmd_code = 1'h0;
  logic ce = 1'h1;
  logic req_valid, req_smm, req_code, cfg_rvalid_o, rsp_valid_o;
  logic rsp_to_dram_o, rsp_to_hub_o, smm_lock_o, gen, opn, cls, lck, xen;
  logic [31:0] req_addr;
  logic [7:0] cfg_rdata_o;
  logic [SLDD_LIM_W-1:0] limit_field_o, lim;
  logic [1:0] xsz;
  int mismatches = 0;
  int num_checks = 0;

  sldd_host_model host (.core_clk_i(core_clk_i), .reset_i(reset_i), .issue_i(issue),
    .addr_i(cmd_addr), .smm_i(cmd_smm), .code_i(cmd_code), .req_valid_o(req_valid),
    .req_addr_o(req_addr), .req_smm_o(req_smm), .req_code_o(req_code));
  sldd_top DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .ext_seg_en_i(ext_seg_en_i), .ext_seg_size_i(ext_seg_size_i),
    .high_smm_en_i(high_smm_en_i), .req_valid_i(req_valid), .req_addr_i(req_addr),
    .req_smm_i(req_smm), .req_code_i(req_code), .rsp_valid_o(rsp_valid_o),
    .rsp_to_dram_o(rsp_to_dram_o), .rsp_to_hub_o(rsp_to_hub_o),
    .smm_lock_o(smm_lock_o), .limit_field_o(limit_field_o));

  initial
    forever #20 core_clk_i = ~core_clk_i;

  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lim_addr();
    return {(lim == 5'h0) ? SLDD_LIM_MIN : lim, 27'h0};
  endfunction

  function automatic logic [31:0] seg_bytes();
    case (xsz)
      SLDD_SZ_1M: return SLDD_BYTES_1M;
      SLDD_SZ_2M: return SLDD_BYTES_2M;
      SLDD_SZ_8M: return SLDD_BYTES_8M;
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic route(input logic [31:0] a, input logic s, input logic c);
    logic [31:0] l;
    l = lim_addr();
    if (a >= SLDD_COMPAT_LO && a <= SLDD_COMPAT_HI)
      return gen && ((opn && !lck) || (s && !(cls && !c)));
    if (gen && xen && xsz != SLDD_SZ_RSVD && a >= l - seg_bytes() && a < l)
      return s || (opn && !lck);
    return a < l;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == SLDD_OFS_LIMIT)
      return {lim, 3'h0};
    if (a == SLDD_OFS_SMMCTL)
      return {1'h0, opn, cls, lck, gen, SLDD_BASE_SEG};
    return 8'h0;
  endfunction

  function automatic logic [31:0] pick_addr();
    case ($urandom_range(4))
      0: return SLDD_COMPAT_LO + $urandom_range(32'h1ffff);
      1: return lim_addr() - $urandom_range(32'h900000);
      2: return lim_addr() - 32'($urandom_range(1));
      3: return lim_addr() - seg_bytes() - 32'($urandom_range(1));
      default: return $urandom;
    endcase
  endfunction

  task automatic do_reset();
    @(posedge core_clk_i);
    reset_i <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'h0;
    {lim, gen, opn, cls, lck} = {SLDD_LIM_MIN, 4'h0};
    {xen, xsz} = {ext_seg_en_i, ext_seg_size_i};
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    {cfg_wr_i, cfg_addr_i, cfg_wdata_i} <= {1'h1, a, d};
    @(posedge core_clk_i);
    cfg_wr_i <= 1'h0;
    if (a == SLDD_OFS_LIMIT)
      lim = d[7:3];
    else if (a == SLDD_OFS_SMMCTL && lck)
      cls = d[5];
    else if (a == SLDD_OFS_SMMCTL)
    begin
      lck = d[4] && (gen || d[3]);
      {gen, cls, opn} = {d[3], d[5], d[6] && !d[4]};
    end
  endtask

  task automatic cfg_read_chk(input logic [7:0] a);
    int n;
    @(posedge core_clk_i);
    {cfg_rd_i, cfg_addr_i} <= {1'h1, a};
    @(posedge core_clk_i);
    cfg_rd_i <= 1'h0;
    n = 0;
    #1;
    while (cfg_rvalid_o !== 1'h1 && n < 4)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check(32'(cfg_rvalid_o), 32'h1);
    check(32'(cfg_rdata_o), 32'(exp_rd(a)));
  endtask

  task automatic set_ext();
    @(posedge core_clk_i);
    {ext_seg_en_i, ext_seg_size_i, high_smm_en_i} <= 4'($urandom);
    #1;
    if (!lck)
      {xen, xsz} = {ext_seg_en_i, ext_seg_size_i};
  endtask

  task automatic do_reqs(input int cnt);
    logic [31:0] a;
    logic s, c, e;
    int n;
    repeat (cnt)
    begin
      {a, s, c} = {pick_addr(), 2'($urandom)};
      e = route(a, s, c);
      @(posedge core_clk_i);
      {issue, cmd_addr, cmd_smm, cmd_code} <= {1'h1, a, s, c};
      @(posedge core_clk_i);
      issue <= 1'h0;
      n = 0;
      #1;
      while (rsp_valid_o !== 1'h1 && n < 6)
      begin
        @(posedge core_clk_i);
        #1;
        n++;
      end
      check({29'h0, rsp_valid_o, rsp_to_dram_o, rsp_to_hub_o}, {29'h0, 1'h1, e, !e});
    end
  endtask

  initial
  begin
    #800000;
    mismatches++;
    complete_run();
  end

  initial
  begin
    logic [7:0] d;
    void'($urandom(32'h422c6879));
    do_reset();
    check(32'(limit_field_o), 32'(SLDD_LIM_MIN));
    cfg_read_chk(SLDD_OFS_LIMIT);
    cfg_read_chk(SLDD_OFS_SMMCTL);
    cfg_read_chk(8'h9e);
    cfg_write(SLDD_OFS_LIMIT, 8'hff);
    cfg_read_chk(SLDD_OFS_LIMIT);
    for (int i = 0; i < 6; i++)
    begin
      cfg_write(SLDD_OFS_LIMIT, (i == 0) ? 8'h0 : (i == 1) ? 8'h08 : 8'($urandom));
      cfg_read_chk(SLDD_OFS_LIMIT);
      check(32'(limit_field_o), 32'(lim));
      do_reqs(12);
    end
    // A write while the clock enable is low must leave the limit untouched.
    d = {lim, 3'h0};
    @(posedge core_clk_i);
    ce <= 1'h0;
    cfg_write(SLDD_OFS_LIMIT, ~d);
    ce <= 1'h1;
    lim = d[7:3];
    cfg_read_chk(SLDD_OFS_LIMIT);
    cfg_write(8'h9e, 8'hff);
    for (int i = 0; i < 24; i++)
    begin
      d = 8'($urandom) & 8'hef;
      if (d[6])
        d[5] = 1'h0;
      cfg_write(SLDD_OFS_SMMCTL, d);
      set_ext();
      cfg_read_chk(SLDD_OFS_SMMCTL);
      do_reqs(8);
    end
    cfg_write(SLDD_OFS_SMMCTL, 8'h00);
    cfg_write(SLDD_OFS_SMMCTL, 8'h50);
    cfg_read_chk(SLDD_OFS_SMMCTL);
    cfg_write(SLDD_OFS_SMMCTL, 8'h48);
    cfg_write(SLDD_OFS_SMMCTL, 8'h58);
    cfg_read_chk(SLDD_OFS_SMMCTL);
    check(32'(smm_lock_o), 32'h1);
    cfg_write(SLDD_OFS_SMMCTL, 8'h20);
    cfg_read_chk(SLDD_OFS_SMMCTL);
    for (int i = 0; i < 4; i++)
    begin
      set_ext();
      do_reqs(10);
    end
    do_reset();
    check(32'(smm_lock_o), 32'h0);
    cfg_write(SLDD_OFS_SMMCTL, 8'h48);
    cfg_write(SLDD_OFS_SMMCTL, 8'h08);
    cfg_write(SLDD_OFS_SMMCTL, 8'h18);
    cfg_read_chk(SLDD_OFS_SMMCTL);
    do_reqs(20);
    complete_run();
  end
endmodule // sldd_top_tb
